// >>> shared/fcp_pkg.sv
// Constants and types for the flash command host controller
package fcp_pkg;
	localparam int unsigned CLK_PERIOD_PS = 5000;
	localparam int unsigned T_SETUP_NS    = 10;
	localparam int unsigned T_WPULSE_NS   = 35;
	localparam int unsigned T_ACCESS_NS   = 70;
	localparam int unsigned T_HOLD_NS     = 10;
	localparam int unsigned SYNC_STAGES   = 2;
	// Least times, rounded up to whole cycles
	localparam int unsigned SETUP_CYC = (T_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned WPULSE_CYC = (T_WPULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned RPULSE_CYC =
		(T_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + SYNC_STAGES;
	localparam int unsigned HOLD_CYC = (T_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// Software register map (word index on the plain port)
	localparam logic [4:0] REG_CMD    = 5'h00;
	localparam logic [4:0] REG_ADDR   = 5'h01;
	localparam logic [4:0] REG_DATA   = 5'h02;
	localparam logic [4:0] REG_STATUS = 5'h03;
	localparam logic [4:0] REG_RESULT = 5'h04;
	localparam logic       REG_BUF_HI = 1'h1;
	localparam int unsigned ST_ERR_BIT = 0;

	// Flash bus patterns
	localparam logic [21:0] UNLOCK_A1   = 22'h000555;
	localparam logic [21:0] UNLOCK_A2   = 22'h0002aa;
	localparam logic [21:0] QUERY_ADDR  = 22'h000055;
	localparam logic [15:0] UNLOCK_D1   = 16'h00aa;
	localparam logic [15:0] UNLOCK_D2   = 16'h0055;
	localparam logic [15:0] OP_RESET    = 16'h00f0;
	localparam logic [15:0] OP_AUTOSEL  = 16'h0090;
	localparam logic [15:0] OP_PROGRAM  = 16'h00a0;
	localparam logic [15:0] OP_BUF_LOAD = 16'h0025;
	localparam logic [15:0] OP_BUF_GO   = 16'h0029;
	localparam logic [15:0] OP_BYPASS   = 16'h0020;
	localparam logic [15:0] OP_ERASE    = 16'h0080;
	localparam logic [15:0] OP_CHIP     = 16'h0010;
	localparam logic [15:0] OP_SECTOR   = 16'h0030;
	localparam logic [15:0] OP_SUSPEND  = 16'h00b0;
	localparam logic [15:0] OP_RESUME   = 16'h0030;
	localparam logic [15:0] OP_QUERY    = 16'h0098;
	localparam logic [15:0] OP_EXIT2    = 16'h0000;
	localparam logic [21:0] ID_LOC0     = 22'h000001;
	localparam logic [21:0] ID_LOC1     = 22'h00000e;
	localparam logic [21:0] ID_LOC2     = 22'h00000f;
	localparam logic [14:0] VERIFY_LOC  = 15'h0002;
	localparam int unsigned SECTOR_LSB  = 15;
	localparam int unsigned PAGE_LSB    = 4;
	localparam int unsigned LIMIT_BIT   = 5;

	typedef enum logic [4:0] {
		C_READ = 5'h00, C_RESET = 5'h01, C_ID = 5'h02, C_VERIFY = 5'h03,
		C_PROGRAM = 5'h04, C_BUFFER = 5'h05, C_ABORT = 5'h06, C_BYP_ENTER = 5'h07,
		C_BYP_PROG = 5'h08, C_BYP_EXIT = 5'h09, C_SECT_ERASE = 5'h0a,
		C_CHIP_ERASE = 5'h0b, C_SUSPEND = 5'h0c, C_RESUME = 5'h0d, C_QUERY = 5'h0e,
		C_PROT_ENTER = 5'h0f, C_PROT_CMD = 5'h10, C_PROT_EXIT = 5'h11,
		C_PROT_READ = 5'h12
	} fcp_cmd_t;

	typedef enum logic [3:0] {
		S_IDLE = 4'h1, S_SETUP = 4'h2, S_PULSE = 4'h4, S_HOLD = 4'h8
	} fcp_fsm_t;

	typedef struct packed {
		logic        rd;
		logic [21:0] addr;
		logic [15:0] data;
	} fcp_cyc_t;

	typedef struct packed {
		logic        ce_n;
		logic        we_n;
		logic        oe_n;
		logic        dq_oe;
		logic [21:0] addr;
		logic [15:0] dq;
	} fcp_pins_t;
endpackage

// >>> design/fcp_host.sv
// Host controller that sequences command cycles onto a parallel NOR flash
// Function
// - Reset command leaves autoselect or recovers errors
// - Autoselect fourth cycle is a read, upper byte ignored (host keeps the whole word in the verify result)
// - Device identification read as three separate reads
// - Buffer locations stay within starting page
// - Word count is locations minus one
// - Buffer sequence at most 21 bus cycles
// - Bypass program only after bypass entry
// - Bypass left only by bypass reset
// - Protection sets entered with three writes, selector
// - Persistent bit programmed by A0 then 00 to sector
// - Protection set must be left by exit sequence (host also clears its protection flag on the reset command)
// - Bad command order needs reset command afterwards
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
module fcp_host (
	input  wire logic              i_ref_clk,
	input  wire logic              i_rstn,
	input  wire logic [4:0]        i_reg_addr,
	input  wire logic [31:0]       i_reg_wdata,
	input  wire logic              i_reg_wr,
	input  wire logic              i_reg_rd,
	output logic [31:0]            o_reg_rdata,
	output logic                   o_busy,
	output fcp_pkg::fcp_pins_t     o_flash,
	input  wire logic [15:0]       i_dq_in
);
	typedef struct packed {
		fcp_pkg::fcp_fsm_t    fsm;
		fcp_pkg::fcp_cmd_t    cmd;
		logic [4:0]           step;
		logic [4:0]           cnt;
		logic [21:0]          addr;
		logic [15:0]          data;
		logic [3:0]           count;
		logic [15:0][15:0]    buffer;
		logic                 bypass;
		logic                 prot;
		logic                 err;
		logic                 limit;
		logic [23:0]          result;
		logic [15:0]          dq_s1;
		logic [15:0]          dq_s2;
		logic [31:0]          rdata;
		logic                 busy;
		fcp_pkg::fcp_pins_t   pins;
	} fcp_state_t;

	fcp_state_t st_reg;
	fcp_state_t st_next;

	// Index of the final bus cycle of each command
	function automatic logic [4:0] last_step(fcp_pkg::fcp_cmd_t c, logic [3:0] n);
		unique case (c)
			fcp_pkg::C_ID:         last_step = 5'h06;
			fcp_pkg::C_VERIFY:     last_step = 5'h04;
			fcp_pkg::C_PROGRAM:    last_step = 5'h03;
			fcp_pkg::C_BUFFER:     last_step = 5'h05 + {1'b0, n};
			fcp_pkg::C_ABORT,
			fcp_pkg::C_BYP_ENTER,
			fcp_pkg::C_PROT_ENTER: last_step = 5'h02;
			fcp_pkg::C_BYP_PROG,
			fcp_pkg::C_BYP_EXIT,
			fcp_pkg::C_PROT_CMD,
			fcp_pkg::C_PROT_EXIT:  last_step = 5'h01;
			fcp_pkg::C_SECT_ERASE,
			fcp_pkg::C_CHIP_ERASE: last_step = 5'h05;
			default:               last_step = 5'h00;
		endcase
	endfunction

	// Commands the flash will take in the current mode
	function automatic logic cmd_ok(fcp_pkg::fcp_cmd_t c, logic byp, logic prt);
		logic p_cmd;
		logic b_cmd;
		p_cmd = (c == fcp_pkg::C_PROT_CMD) || (c == fcp_pkg::C_PROT_EXIT)
			|| (c == fcp_pkg::C_PROT_READ);
		b_cmd = (c == fcp_pkg::C_BYP_PROG) || (c == fcp_pkg::C_BYP_EXIT);
		if (prt) begin
			cmd_ok = p_cmd || (c == fcp_pkg::C_RESET);
		end else if (byp) begin
			cmd_ok = b_cmd || (c == fcp_pkg::C_READ);
		end else begin
			// Codes past the table would run a stray unlock cycle
			cmd_ok = !p_cmd && !b_cmd && (c <= fcp_pkg::C_PROT_READ);
		end
	endfunction

	// Address, data and direction of one bus cycle
	function automatic fcp_pkg::fcp_cyc_t cycle(fcp_pkg::fcp_cmd_t c, logic [4:0] s,
			logic [21:0] a, logic [15:0] d, logic [3:0] n, logic [15:0][15:0] b);
		fcp_pkg::fcp_cyc_t y;
		logic [3:0] idx;
		logic [21:0] sa;
		idx = s[3:0] - 4'h4;
		sa = {a[21:fcp_pkg::SECTOR_LSB], 15'h0000};
		y.rd = 1'b0;
		y.addr = (s == 5'h00) ? fcp_pkg::UNLOCK_A1 : fcp_pkg::UNLOCK_A2;
		y.data = (s == 5'h00) ? fcp_pkg::UNLOCK_D1 : fcp_pkg::UNLOCK_D2;
		unique case (c)
			fcp_pkg::C_READ, fcp_pkg::C_PROT_READ: begin
				y.rd = 1'b1;
				y.addr = a;
			end
			fcp_pkg::C_RESET: y.data = fcp_pkg::OP_RESET;
			fcp_pkg::C_ID, fcp_pkg::C_VERIFY: begin
				if (s == 5'h02) begin
					y.addr = fcp_pkg::UNLOCK_A1;
					y.data = fcp_pkg::OP_AUTOSEL;
				end else if (s == last_step(c, n)) begin
					y.data = fcp_pkg::OP_RESET;
				end else if (s > 5'h02) begin
					y.rd = 1'b1;
					if (c == fcp_pkg::C_VERIFY) begin
						y.addr = {a[21:fcp_pkg::SECTOR_LSB], fcp_pkg::VERIFY_LOC};
					end else if (s == 5'h03) begin
						y.addr = fcp_pkg::ID_LOC0;
					end else begin
						y.addr = (s == 5'h04) ? fcp_pkg::ID_LOC1 : fcp_pkg::ID_LOC2;
					end
				end
			end
			fcp_pkg::C_PROGRAM, fcp_pkg::C_ABORT, fcp_pkg::C_BYP_ENTER,
			fcp_pkg::C_PROT_ENTER: begin
				if (s == 5'h02) begin
					y.addr = fcp_pkg::UNLOCK_A1;
					unique case (c)
						fcp_pkg::C_PROGRAM:   y.data = fcp_pkg::OP_PROGRAM;
						fcp_pkg::C_ABORT:     y.data = fcp_pkg::OP_RESET;
						fcp_pkg::C_BYP_ENTER: y.data = fcp_pkg::OP_BYPASS;
						default:              y.data = {8'h00, d[7:0]};
					endcase
				end else if (s == 5'h03) begin
					y.addr = a;
					y.data = d;
				end
			end
			fcp_pkg::C_BUFFER: begin
				if (s == 5'h02 || s == 5'h03) begin
					y.addr = sa;
					y.data = (s == 5'h02) ? fcp_pkg::OP_BUF_LOAD : {12'h000, n};
				end else if (s == last_step(c, n)) begin
					y.addr = sa;
					y.data = fcp_pkg::OP_BUF_GO;
				end else if (s > 5'h03) begin
					// Offset wraps inside the page, never into the next one
					y.addr = {a[21:fcp_pkg::PAGE_LSB], a[3:0] + idx};
					y.data = b[idx];
				end
			end
			fcp_pkg::C_BYP_PROG, fcp_pkg::C_PROT_CMD: begin
				y.addr = (s == 5'h00) ? fcp_pkg::UNLOCK_A1 : a;
				y.data = (s == 5'h00) ? fcp_pkg::OP_PROGRAM : d;
			end
			fcp_pkg::C_BYP_EXIT, fcp_pkg::C_PROT_EXIT: begin
				y.data = (s == 5'h00) ? fcp_pkg::OP_AUTOSEL : fcp_pkg::OP_EXIT2;
			end
			fcp_pkg::C_SECT_ERASE, fcp_pkg::C_CHIP_ERASE: begin
				if (s == 5'h02) begin
					y.addr = fcp_pkg::UNLOCK_A1;
					y.data = fcp_pkg::OP_ERASE;
				end else if (s == 5'h03) begin
					y.data = fcp_pkg::UNLOCK_D1;
					y.addr = fcp_pkg::UNLOCK_A1;
				end else if (s == 5'h05) begin
					y.addr = (c == fcp_pkg::C_SECT_ERASE) ? sa : fcp_pkg::UNLOCK_A1;
					y.data = (c == fcp_pkg::C_SECT_ERASE) ? fcp_pkg::OP_SECTOR
						: fcp_pkg::OP_CHIP;
				end
			end
			fcp_pkg::C_SUSPEND: y.data = fcp_pkg::OP_SUSPEND;
			fcp_pkg::C_RESUME:  y.data = fcp_pkg::OP_RESUME;
			fcp_pkg::C_QUERY: begin
				y.addr = fcp_pkg::QUERY_ADDR;
				y.data = fcp_pkg::OP_QUERY;
			end
			default: y.rd = 1'b0;
		endcase
		cycle = y;
	endfunction

	fcp_pkg::fcp_cyc_t cur;
	logic              last;
	fcp_pkg::fcp_cmd_t new_cmd;

	always_comb begin
		cur = cycle(st_reg.cmd, st_reg.step, st_reg.addr, st_reg.data, st_reg.count,
			st_reg.buffer);
		last = (st_reg.step == last_step(st_reg.cmd, st_reg.count));
		new_cmd = fcp_pkg::fcp_cmd_t'(i_reg_wdata[4:0]);
		st_next = st_reg;
		st_next.dq_s1 = i_dq_in;
		st_next.dq_s2 = st_reg.dq_s1;
		st_next.rdata = 32'h0000_0000;
		if (i_reg_rd) begin
			unique case (i_reg_addr)
				fcp_pkg::REG_ADDR:   st_next.rdata = {10'h000, st_reg.addr};
				fcp_pkg::REG_DATA:   st_next.rdata = {16'h0000, st_reg.data};
				fcp_pkg::REG_STATUS: st_next.rdata = {27'h0000000, st_reg.limit,
					st_reg.prot, st_reg.bypass, st_reg.busy, st_reg.err};
				fcp_pkg::REG_RESULT: st_next.rdata = {8'h00, st_reg.result};
				default: st_next.rdata = 32'h0000_0000;
			endcase
		end
		if (i_reg_wr) begin
			if (i_reg_addr[4] == fcp_pkg::REG_BUF_HI) begin
				st_next.buffer[i_reg_addr[3:0]] = i_reg_wdata[15:0];
			end else if (i_reg_addr == fcp_pkg::REG_ADDR) begin
				st_next.addr = i_reg_wdata[21:0];
			end else if (i_reg_addr == fcp_pkg::REG_DATA) begin
				st_next.data = i_reg_wdata[15:0];
			end else if (i_reg_addr == fcp_pkg::REG_STATUS
					&& i_reg_wdata[fcp_pkg::ST_ERR_BIT]) begin
				st_next.err = 1'b0;
			end else if (i_reg_addr == fcp_pkg::REG_CMD) begin
				// Refused orders only raise the sticky error flag
				if (st_reg.busy || !cmd_ok(new_cmd, st_reg.bypass, st_reg.prot)) begin
					st_next.err = 1'b1;
				end else begin
					st_next.cmd = new_cmd;
					st_next.count = i_reg_wdata[11:8];
					st_next.step = 5'h00;
					st_next.busy = 1'b1;
					st_next.fsm = fcp_pkg::S_SETUP;
					// First setup cycle still has select high, so count one more
					st_next.cnt = 5'(fcp_pkg::SETUP_CYC);
				end
			end
		end
		unique case (st_reg.fsm)
			fcp_pkg::S_IDLE: begin
				st_next.pins.ce_n = 1'b1;
			end
			fcp_pkg::S_SETUP: begin
				st_next.pins.ce_n = 1'b0;
				st_next.pins.addr = cur.addr;
				st_next.pins.dq = cur.data;
				st_next.pins.dq_oe = !cur.rd;
				st_next.cnt = st_reg.cnt - 5'h01;
				if (st_reg.cnt == 5'h00) begin
					st_next.fsm = fcp_pkg::S_PULSE;
					st_next.pins.we_n = cur.rd;
					st_next.pins.oe_n = !cur.rd;
					st_next.cnt = cur.rd ? 5'(fcp_pkg::RPULSE_CYC - 1)
						: 5'(fcp_pkg::WPULSE_CYC - 1);
				end
			end
			fcp_pkg::S_PULSE: begin
				st_next.cnt = st_reg.cnt - 5'h01;
				if (st_reg.cnt == 5'h00) begin
					// Write strobe rises first; data stays put through hold
					st_next.pins.we_n = 1'b1;
					st_next.pins.oe_n = 1'b1;
					st_next.fsm = fcp_pkg::S_HOLD;
					st_next.cnt = 5'(fcp_pkg::HOLD_CYC - 1);
					if (cur.rd) begin
						st_next.limit = st_reg.dq_s2[fcp_pkg::LIMIT_BIT];
						if (st_reg.cmd == fcp_pkg::C_ID) begin
							st_next.result = {st_reg.result[15:0], st_reg.dq_s2[7:0]};
						end else begin
							st_next.result = {8'h00, st_reg.dq_s2};
						end
					end
				end
			end
			fcp_pkg::S_HOLD: begin
				st_next.cnt = st_reg.cnt - 5'h01;
				if (st_reg.cnt == 5'h00) begin
					st_next.pins.ce_n = 1'b1;
					st_next.pins.dq_oe = 1'b0;
					st_next.step = st_reg.step + 5'h01;
					st_next.fsm = fcp_pkg::S_SETUP;
					st_next.cnt = 5'(fcp_pkg::SETUP_CYC);
					if (last) begin
						st_next.fsm = fcp_pkg::S_IDLE;
						st_next.busy = 1'b0;
						if (st_reg.cmd == fcp_pkg::C_BYP_ENTER) st_next.bypass = 1'b1;
						if (st_reg.cmd == fcp_pkg::C_BYP_EXIT) st_next.bypass = 1'b0;
						if (st_reg.cmd == fcp_pkg::C_PROT_ENTER) st_next.prot = 1'b1;
						if (st_reg.cmd == fcp_pkg::C_PROT_EXIT) st_next.prot = 1'b0;
						if (st_reg.cmd == fcp_pkg::C_RESET) st_next.prot = 1'b0;
					end
				end
			end
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			st_reg <= '0;
			st_reg.fsm <= fcp_pkg::S_IDLE;
			st_reg.cmd <= fcp_pkg::C_READ;
			st_reg.pins.ce_n <= 1'b1;
			st_reg.pins.we_n <= 1'b1;
			st_reg.pins.oe_n <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_reg_rdata = st_reg.rdata;
	assign o_busy = st_reg.busy;
	assign o_flash = st_reg.pins;

	logic in_buf_word;
	assign in_buf_word = st_reg.cmd == fcp_pkg::C_BUFFER && st_reg.step > 5'h03 && !last;

	a_buf_length: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		st_reg.busy && st_reg.cmd == fcp_pkg::C_BUFFER |-> st_reg.step <= 5'd20)
		else $error("buffer sequence exceeds 21 cycles");
	a_buf_page: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		!o_flash.we_n && in_buf_word |-> o_flash.addr[21:4] == st_reg.addr[21:4])
		else $error("buffer location outside page");
	a_word_count: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		!o_flash.we_n && st_reg.cmd == fcp_pkg::C_BUFFER && st_reg.step == 5'h03
		|-> o_flash.dq == {12'h000, st_reg.count})
		else $error("word count field wrong");
	a_bypass_gate: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		$rose(st_reg.busy) && st_reg.cmd == fcp_pkg::C_BYP_PROG |-> st_reg.bypass)
		else $error("bypass program outside bypass mode");
	a_bypass_leave: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		$fell(st_reg.bypass) |-> $past(st_reg.cmd) == fcp_pkg::C_BYP_EXIT && $fell(st_reg.busy))
		else $error("bypass left without bypass reset");
	a_prot_leave: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		$fell(st_reg.prot) |-> $past(st_reg.cmd) == fcp_pkg::C_PROT_EXIT
		|| $past(st_reg.cmd) == fcp_pkg::C_RESET)
		else $error("protection set left without exit");
	a_entry_code: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		!o_flash.we_n && st_reg.cmd == fcp_pkg::C_PROT_ENTER && st_reg.step == 5'h02
		|-> o_flash.addr == fcp_pkg::UNLOCK_A1 && o_flash.dq[7:0] == st_reg.data[7:0])
		else $error("protection entry selector wrong");
	a_auto_reset: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		$fell(st_reg.busy) && ($past(st_reg.cmd) == fcp_pkg::C_ID
		|| $past(st_reg.cmd) == fcp_pkg::C_VERIFY) |-> $past(o_flash.dq, 3) == fcp_pkg::OP_RESET)
		else $error("autoselect not closed by reset command");
	a_write_pulse: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		$fell(o_flash.we_n) |-> (!o_flash.we_n)[*7] ##1 o_flash.we_n ##1 $stable(o_flash.dq))
		else $error("write pulse width or data hold wrong");
	a_read_float: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		!o_flash.oe_n |-> !o_flash.dq_oe && o_flash.we_n)
		else $error("host drives data during read");

	c_buffer_done: cover property (@(posedge i_ref_clk) disable iff (!i_rstn)
		$fell(st_reg.busy) && st_reg.cmd == fcp_pkg::C_BUFFER);
	c_id_read: cover property (@(posedge i_ref_clk) disable iff (!i_rstn)
		$fell(st_reg.busy) && st_reg.cmd == fcp_pkg::C_ID);
	c_prot_entry: cover property (@(posedge i_ref_clk) disable iff (!i_rstn)
		$rose(st_reg.prot));
	c_bypass_prog: cover property (@(posedge i_ref_clk) disable iff (!i_rstn)
		$fell(st_reg.busy) && st_reg.cmd == fcp_pkg::C_BYP_PROG);
endmodule // fcp_host
`default_nettype wire

// >>> tb/fcp_flash_model.sv
// Behavioural flash device answering the host controller's bus cycles
`timescale 1ns/1ps
`default_nettype none
module fcp_flash_model #(
	parameter logic [7:0] ID0 = 8'h11, // Arbitrary identification bytes
	parameter logic [7:0] ID1 = 8'h22,
	parameter logic [7:0] ID2 = 8'h33
) (
	input  wire fcp_pkg::fcp_pins_t i_pins,
	input  wire logic [15:0]        i_dq,
	input  wire logic               i_slow,
	output logic [15:0]             o_dq
);
	logic [7:0]   mode;
	logic [7:0]   c;
	logic [1:0]   step;
	logic [1:0]   bst;
	logic         arm;
	logic         ex;
	logic         frz;
	logic [127:0] pbit;
	logic [127:0] vbit;
	logic [21:0]  a;
	int           bcnt;
	logic [15:0]  mem [int];

	initial begin
		{mode, step, bst, arm, ex, frz, pbit, vbit} = '0;
		o_dq = 16'h0000;
	end

	function automatic logic [15:0] rdv(input logic [21:0] x);
		// Upper byte is noise on identification reads
		case (mode)
			8'h90: case (x[14:0])
				fcp_pkg::ID_LOC0[14:0]: return {~x[7:0], ID0};
				fcp_pkg::ID_LOC1[14:0]: return {~x[7:0], ID1};
				fcp_pkg::ID_LOC2[14:0]: return {~x[7:0], ID2};
				fcp_pkg::VERIFY_LOC: return {~x[7:0], 7'h00, pbit[x[21:15]] | vbit[x[21:15]]};
				default: return ~x[15:0];
			endcase
			8'hc0: return {15'h7fff, ~pbit[x[21:15]]};
			8'he0: return {15'h7fff, ~vbit[x[21:15]]};
			8'h50: return {15'h7fff, ~frz};
			default: return mem.exists(int'(x)) ? mem[int'(x)] : x[15:0] ^ 16'h5a5a;
		endcase
	endfunction

	// Slow mode leaves data settling close to the end of the strobe
	always @(negedge i_pins.oe_n) begin
		o_dq = ~o_dq;
		#(i_slow ? 65 : 10);
		if (!i_pins.oe_n && !i_pins.ce_n)
			o_dq = rdv(i_pins.addr);
	end
	// Released bus never keeps the last value
	always @(posedge i_pins.oe_n) #5 o_dq = ~o_dq;

	always @(posedge i_pins.we_n) begin
		if (!i_pins.ce_n) begin // Taken at first rising strobe
			a = i_pins.addr;
			c = i_dq[7:0];
			if (arm) begin
				arm = 1'b0;
				case (mode)
					8'hc0: if (c == 8'h00) pbit[a[21:15]] = 1'b1;
					8'he0: vbit[a[21:15]] = ~c[0];
					8'h50: frz = 1'b1;
					default: mem[int'(a)] = i_dq;
				endcase
			end else if (bst == 2'd1) begin
				bcnt = int'(i_dq) + 1; // Count is locations minus one
				bst = 2'd2;
			end else if (bst == 2'd2) begin
				if (bcnt > 0)
					mem[int'(a)] = i_dq;
				else
					bst = 2'd0;
				bcnt--;
			end else if (ex) begin
				ex = 1'b0;
				if (c == 8'h00)
					mode = 8'h00;
			end else if (mode != 8'h00 && mode != 8'h90) begin
				arm = (c == 8'ha0); // Bypass program needs bypass mode
				ex = (c == 8'h90);
			end else if (c == 8'hf0) begin
				mode = 8'h00;
				step = 2'd0;
			end else if (step == 2'd0)
				step = {1'b0, a[10:0] == 11'h555 && c == 8'haa}; // Low bits only
			else if (step == 2'd1)
				step = (a[10:0] == 11'h2aa && c == 8'h55) ? 2'd2 : 2'd0;
			else begin
				step = 2'd0;
				case (c)
					8'h90, 8'h20, 8'h40, 8'h60, 8'hc0, 8'h50, 8'he0: mode = c;
					8'ha0: arm = 1'b1;
					8'h25: bst = 2'd1;
					default: ;
				endcase
			end
		end
	end
endmodule // fcp_flash_model
`default_nettype wire

// >>> tb/fcp_host_tb.sv
// Self-checking bench for the flash command host controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module fcp_host_tb;
	localparam logic [7:0] ID0 = 8'h4c; // Arbitrary identification bytes
	localparam logic [7:0] ID1 = 8'h9d;
	localparam logic [7:0] ID2 = 8'h3a;
	logic               i_ref_clk = 1'b0;
	logic               i_rstn = 1'b0;
	logic [4:0]         ra = 5'h00;
	logic [31:0]        rwd = 32'h0;
	logic               rwr = 1'b0;
	logic               rrd = 1'b0;
	logic               slow = 1'b0;
	logic               rp = 1'b0;
	logic [31:0]        rdata;
	logic               busy;
	fcp_pkg::fcp_pins_t fl;
	logic [15:0]        mdq;
	wire logic [15:0]   dqb;
	logic [38:0]        wq[$];
	logic [63:0]        rq[$];
	logic [38:0]        we;
	logic [63:0]        re;
	logic [21:0]        a;
	logic [21:0]        sa;
	logic [15:0]        d;
	logic [15:0]        bd [16];
	logic [7:0]         sels [5] = '{8'h40, 8'h60, 8'hc0, 8'h50, 8'he0};
	int                 err_count = 0;
	int                 total_checks = 0;
	int                 seed = 70;

	assign dqb = fl.dq_oe ? fl.dq : mdq;
	always #2.5 i_ref_clk = ~i_ref_clk;

	fcp_host uut (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_reg_addr(ra), .i_reg_wdata(rwd),
		.i_reg_wr(rwr), .i_reg_rd(rrd), .o_reg_rdata(rdata), .o_busy(busy), .o_flash(fl),
		.i_dq_in(dqb));
	fcp_flash_model #(.ID0(ID0), .ID1(ID1), .ID2(ID2)) fm (.i_pins(fl), .i_dq(dqb),
		.i_slow(slow), .o_dq(mdq));

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic wr(input logic [4:0] ad, input logic [31:0] v);
		@(posedge i_ref_clk);
		ra <= ad;
		rwd <= v;
		rwr <= 1'b1;
		@(posedge i_ref_clk);
		rwr <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] ad, input logic [31:0] m, input logic [31:0] e);
		@(posedge i_ref_clk);
		ra <= ad;
		rrd <= 1'b1;
		rq.push_back({m, e});
		@(posedge i_ref_clk);
		rrd <= 1'b0;
	endtask
	task automatic ew(input logic c, input logic [21:0] ad, input logic [15:0] v);
		wq.push_back({c, ad, v});
	endtask
	task automatic u3(input logic [15:0] op);
		ew(1, fcp_pkg::UNLOCK_A1, fcp_pkg::UNLOCK_D1);
		ew(1, fcp_pkg::UNLOCK_A2, fcp_pkg::UNLOCK_D2);
		if (op != 16'hffff)
			ew(1, fcp_pkg::UNLOCK_A1, op);
	endtask
	task automatic wt;
		int n;
		n = 0;
		repeat (2) @(posedge i_ref_clk);
		while (busy !== 1'b0 && n < 4000) begin
			@(posedge i_ref_clk);
			n++;
		end
		`CHK(busy, 1'b0)
		`CHK(wq.size(), 0)
	endtask
	task automatic go(input logic [31:0] c, input logic [21:0] ad, input logic [15:0] v);
		wr(fcp_pkg::REG_ADDR, {10'h0, ad});
		wr(fcp_pkg::REG_DATA, {16'h0, v});
		wr(fcp_pkg::REG_CMD, c);
		wt();
	endtask

	// Register read answers land one cycle after the strobe
	always @(posedge i_ref_clk) begin
		if (rp) begin
			re = rq.pop_front();
			`CHK(rdata & re[63:32], re[31:0])
		end
		rp <= rrd;
	end
	// Every flash write is matched against the oldest noted cycle
	always @(posedge fl.we_n) begin
		if (fl.ce_n === 1'b0) begin
			we = (wq.size() > 0) ? wq.pop_front() : '1;
			if (we[38])
				`CHK({fl.addr, dqb}, we[37:0])
			else
				`CHK(dqb, we[15:0])
		end
	end

	initial begin
		#200000;
		err_count++;
		tally_and_finish();
	end

	initial begin
		repeat (12) @(posedge i_ref_clk);
		i_rstn <= 1'b1;
		`CHK({fl.ce_n, fl.we_n, fl.oe_n, fl.dq_oe, busy}, 5'b11100)
		rd(fcp_pkg::REG_STATUS, 32'hf, 32'h0);
		a = 22'($random(seed));
		d = 16'($random(seed));
		go(0, a, 0);
		rd(fcp_pkg::REG_RESULT, 32'hffff, {16'h0, a[15:0] ^ 16'h5a5a});
		u3(fcp_pkg::OP_PROGRAM);
		ew(1, a, d);
		go(4, a, d);
		go(0, a, 0);
		rd(fcp_pkg::REG_RESULT, 32'hffff, {16'h0, d});
		$display("test read and program done");
		slow <= 1'b1;
		u3(fcp_pkg::OP_AUTOSEL);
		ew(0, 0, fcp_pkg::OP_RESET);
		go(2, a, 0);
		rd(fcp_pkg::REG_RESULT, 32'hffffff, {8'h0, ID0, ID1, ID2});
		slow <= 1'b0;
		$display("test identification done");
		go(32'h10, a, 0);
		go(32'h08, a, 0);
		rd(fcp_pkg::REG_STATUS, 32'h1, 32'h1);
		wr(fcp_pkg::REG_STATUS, 32'h1);
		wr(fcp_pkg::REG_CMD, 32'h0);
		wr(fcp_pkg::REG_CMD, 32'h4);
		wt();
		rd(fcp_pkg::REG_STATUS, 32'h1, 32'h1);
		wr(fcp_pkg::REG_STATUS, 32'h1);
		$display("test refusals done");
		u3(fcp_pkg::OP_BYPASS);
		go(7, a, 0);
		rd(fcp_pkg::REG_STATUS, 32'h4, 32'h4);
		d = 16'($random(seed));
		ew(0, 0, fcp_pkg::OP_PROGRAM);
		ew(1, a, d);
		go(8, a, d);
		go(0, a, 0);
		rd(fcp_pkg::REG_RESULT, 32'hffff, {16'h0, d});
		go(1, a, 0);
		rd(fcp_pkg::REG_STATUS, 32'h5, 32'h5);
		wr(fcp_pkg::REG_STATUS, 32'h1);
		ew(0, 0, fcp_pkg::OP_AUTOSEL);
		ew(0, 0, fcp_pkg::OP_EXIT2);
		go(9, a, 0);
		rd(fcp_pkg::REG_STATUS, 32'h4, 32'h0);
		$display("test bypass done");
		foreach (sels[k]) begin
			u3({8'h0, sels[k]});
			go(15, a, {8'h0, sels[k]});
			rd(fcp_pkg::REG_STATUS, 32'h8, 32'h8);
			if (sels[k] == 8'hc0 || sels[k] == 8'h50) begin
				go(18, a, 0);
				rd(fcp_pkg::REG_RESULT, 32'h1, 32'h1);
				ew(0, 0, fcp_pkg::OP_PROGRAM);
				ew(0, a, 16'h0000);
				go(16, a, 0);
				go(18, a, 0);
				rd(fcp_pkg::REG_RESULT, 32'h1, 32'h0);
			end
			ew(0, 0, fcp_pkg::OP_AUTOSEL);
			ew(0, 0, fcp_pkg::OP_EXIT2);
			go(17, a, 0);
			rd(fcp_pkg::REG_STATUS, 32'h8, 32'h0);
		end
		for (int k = 0; k < 2; k++) begin
			u3(fcp_pkg::OP_AUTOSEL);
			ew(0, 0, fcp_pkg::OP_RESET);
			go(3, a ^ (k ? 22'h008000 : 22'h0), 0);
			rd(fcp_pkg::REG_RESULT, 32'hff, k ? 32'h0 : 32'h1);
		end
		$display("test protection done");
		sa = {a[21:15], 15'h0};
		u3(16'hffff);
		ew(1, sa, fcp_pkg::OP_BUF_LOAD);
		ew(1, sa, 16'h000f);
		for (int k = 0; k < 16; k++) begin
			bd[k] = 16'($random(seed));
			wr({1'b1, 4'(k)}, {16'h0, bd[k]});
			ew(1, {a[21:4], a[3:0] + 4'(k)}, bd[k]);
		end
		ew(1, sa, fcp_pkg::OP_BUF_GO);
		go(32'h0f05, a, 0);
		$display("test buffer done");
		u3(fcp_pkg::OP_RESET);
		go(6, a, 0);
		ew(0, 0, fcp_pkg::OP_RESET);
		go(1, a, 0);
		u3(fcp_pkg::OP_ERASE);
		u3(16'hffff);
		ew(1, sa, fcp_pkg::OP_SECTOR);
		go(10, a, 0);
		u3(fcp_pkg::OP_ERASE);
		u3(fcp_pkg::OP_CHIP);
		go(11, a, 0);
		ew(0, 0, fcp_pkg::OP_SUSPEND);
		go(12, a, 0);
		ew(0, 0, fcp_pkg::OP_RESUME);
		go(13, a, 0);
		ew(1, fcp_pkg::QUERY_ADDR, fcp_pkg::OP_QUERY);
		go(14, a, 0);
		rd(fcp_pkg::REG_STATUS, 32'h1, 32'h0);
		$display("test erase and query done");
		repeat (3) @(posedge i_ref_clk);
		tally_and_finish();
	end
endmodule // fcp_host_tb
`default_nettype wire
